// ==== rtl/cso_core_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// - Status register is a legal destination like any other register.
// - Flags the instruction updates take the result, not the written data.
// - Software writes never change the watchdog expiry or sleep flags.
// - Clearing status zeroes the bank bits and sets the zero flag.
// - Two bank bits pick one of four 128-byte banks for direct access.
// - Subtraction adds two's complement; carries read as inverted borrow.
// - Rotates load carry with the bit shifted out of the source.
// - Power reset gives 0001 1000; other resets clear bank bits and load the expiry flag with the inverse of the watchdog cause.
// - Pull disable bit turns all pulls off, else each follows its latch.
// - Interrupt pin edge bit picks rising (1) or falling (0) edge.
// - Tick source bit picks the external pin or the instruction clock.
// - Tick edge bit picks falling (1) or rising (0) pin edges.
// - Owner bit gives the shared prescaler to watchdog (1) or timer (0).
// - Ratio code gives 1:2..1:256 for timer, 1:1..1:128 for watchdog.
// - Option register is fully read/write and resets to all ones.
module cso_core_regs (
   // Clock and resets
   input  wire logic             MCLK,
   input  wire logic             RESET,
   input  wire logic             SOFT_RESET,
   input  wire logic             SOFT_RST_WDT,
   // Register access
   input  wire logic             REG_WR_EN,
   input  wire logic [8:0]       REG_ADDR,
   input  wire logic [7:0]       REG_WR_DATA,
   output logic [7:0]            REG_RD_DATA,
   // ALU operation
   input  wire cso_pkg::cso_op_t ALU_OP,
   input  wire logic [7:0]       ALU_A,
   input  wire logic [7:0]       ALU_B,
   input  wire logic [2:0]       FLAG_UPD,
   output logic [7:0]            ALU_RESULT,
   // Addressing
   input  wire logic [6:0]       FILE_ADDR,
   input  wire logic [7:0]       FSR_VAL,
   output logic [8:0]            DIRECT_ADDR,
   output logic [8:0]            INDIRECT_ADDR,
   // Power events
   input  wire logic             CLRWDT_EV,
   input  wire logic             SLEEP_EV,
   input  wire logic             WDT_TIMEOUT_EV,
   // Port pulls
   input  wire logic [5:0]       PORT_LATCH,
   output logic [5:0]            PULL_EN,
   // Interrupt pin
   input  wire logic             EXT_IRQ_PIN,
   output logic                  EXT_IRQ_EVENT,
   // Timer and watchdog ticks
   input  wire logic             EXT_TICK_PIN,
   input  wire logic             INSTR_CYCLE_EN,
   input  wire logic             WDT_BASE_TICK,
   output logic                  TMR_TICK,
   output logic                  WDT_TICK
);

   cso_pkg::cso_status_t status_reg;
   cso_pkg::cso_status_t status_next;
   cso_pkg::cso_option_t option_reg;
   cso_pkg::cso_option_t option_next;
   cso_pkg::cso_status_t wr_view;
   cso_pkg::cso_flags_t  alu_flags;
   logic [7:0]           rd_reg;
   logic [7:0]           rd_next;
   logic [5:0]           pull_reg;
   logic [5:0]           pull_next;
   logic                 irq_pin_reg;
   logic                 irq_pin_next;
   logic                 tick_pin_reg;
   logic                 tick_pin_next;
   logic                 wr_status;
   logic                 wr_option;
   logic                 tick_edge;
   logic                 tmr_src;

   cso_flag_unit u_flags (
      .op       (ALU_OP),
      .a        (ALU_A),
      .b        (ALU_B),
      .carry_in (status_reg.carry),
      .result   (ALU_RESULT),
      .flags    (alu_flags)
   );

   always_comb
   begin
      wr_status = REG_WR_EN && (REG_ADDR[6:0] == cso_pkg::STATUS_LOW);
      wr_option = REG_WR_EN && (REG_ADDR == cso_pkg::OPTION_ADDR);
      wr_view   = cso_pkg::cso_status_t'(REG_WR_DATA);
      status_next = status_reg;
      option_next = option_reg;
      if (wr_status)
      begin
         // Expiry and sleep flags are left out of the write on purpose
         status_next.indirect_bank_bit    = wr_view.indirect_bank_bit;
         status_next.direct_bank_sel      = wr_view.direct_bank_sel;
      end
      // A flag-setting instruction blocks the data write to all three flags
      if (wr_status && !(|FLAG_UPD))
      begin
         status_next.zero                 = wr_view.zero;
         status_next.nibble_overflow_flag = wr_view.nibble_overflow_flag;
         status_next.carry                = wr_view.carry;
      end
      // Flag results override any data written to the same bits
      if (FLAG_UPD[cso_pkg::FLG_Z])
         status_next.zero = alu_flags.zero;
      if (FLAG_UPD[cso_pkg::FLG_DC])
         status_next.nibble_overflow_flag =
            alu_flags.nibble_overflow_flag;
      if (FLAG_UPD[cso_pkg::FLG_C])
         status_next.carry = alu_flags.carry;
      if (CLRWDT_EV)
      begin
         status_next.wdt_expiry_flag  = 1'b1;
         status_next.sleep_entry_flag = 1'b1;
      end
      if (SLEEP_EV)
      begin
         status_next.wdt_expiry_flag  = 1'b1;
         status_next.sleep_entry_flag = 1'b0;
      end
      // A timeout wins over a clear landing in the same cycle
      if (WDT_TIMEOUT_EV)
         status_next.wdt_expiry_flag = 1'b0;
      if (wr_option)
         option_next = cso_pkg::cso_option_t'(REG_WR_DATA);
      if (SOFT_RESET)
      begin
         status_next.indirect_bank_bit = 1'b0;
         status_next.direct_bank_sel   = 2'b00;
         status_next.wdt_expiry_flag   = ~SOFT_RST_WDT;
         status_next.sleep_entry_flag  = status_reg.sleep_entry_flag;
         status_next.zero                 = status_reg.zero;
         status_next.nibble_overflow_flag = status_reg.nibble_overflow_flag;
         status_next.carry                = status_reg.carry;
         option_next = cso_pkg::cso_option_t'(cso_pkg::OPTION_RST);
      end
      if (REG_ADDR[6:0] == cso_pkg::STATUS_LOW)
         rd_next = status_reg;
      else if (REG_ADDR == cso_pkg::OPTION_ADDR)
         rd_next = option_reg;
      else
         rd_next = cso_pkg::READ_ZERO;
      pull_next = option_reg.pull_resistor_disable ? 6'h00
                                                   : PORT_LATCH;
      irq_pin_next  = EXT_IRQ_PIN;
      tick_pin_next = EXT_TICK_PIN;
   end

   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         status_reg   <= cso_pkg::cso_status_t'({cso_pkg::STATUS_PWR_HI,
                                                 cso_pkg::ALU_FLAG_RST});
         option_reg   <= cso_pkg::cso_option_t'(cso_pkg::OPTION_RST);
         rd_reg       <= cso_pkg::READ_ZERO;
         pull_reg     <= 6'h00;
         irq_pin_reg  <= 1'b0;
         tick_pin_reg <= 1'b0;
      end
      else
      begin
         status_reg   <= status_next;
         option_reg   <= option_next;
         rd_reg       <= rd_next;
         pull_reg     <= pull_next;
         irq_pin_reg  <= irq_pin_next;
         tick_pin_reg <= tick_pin_next;
      end
   end

   always_comb
   begin
      REG_RD_DATA   = rd_reg;
      PULL_EN       = pull_reg;
      DIRECT_ADDR   = {status_reg.direct_bank_sel, FILE_ADDR};
      INDIRECT_ADDR = {status_reg.indirect_bank_bit, FSR_VAL};
      EXT_IRQ_EVENT = option_reg.pin_irq_edge
                      ? (EXT_IRQ_PIN && !irq_pin_reg)
                      : (!EXT_IRQ_PIN && irq_pin_reg);
      tick_edge     = option_reg.tick_edge_pick
                      ? (!EXT_TICK_PIN && tick_pin_reg)
                      : (EXT_TICK_PIN && !tick_pin_reg);
      tmr_src       = option_reg.tick_source_sel ? tick_edge
                                                 : INSTR_CYCLE_EN;
   end

   cso_prescaler u_prescale (
      .clk      (MCLK),
      .rst      (RESET),
      .owner    (option_reg.prescale_owner),
      .ratio    (option_reg.prescale_ratio),
      .tmr_in   (tmr_src),
      .wdt_in   (WDT_BASE_TICK),
      .tmr_tick (TMR_TICK),
      .wdt_tick (WDT_TICK)
   );

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   flags_readonly_a: assert property (
      !CLRWDT_EV && !SLEEP_EV && !WDT_TIMEOUT_EV && !SOFT_RESET
      |=> $stable({status_reg.wdt_expiry_flag,
                   status_reg.sleep_entry_flag}))
      else $error("expiry or sleep flag changed without an event");

   flag_override_a: assert property (
      FLAG_UPD[cso_pkg::FLG_Z] && !SOFT_RESET
      |=> status_reg.zero == $past(alu_flags.zero))
      else $error("zero flag does not follow the result");

   bank_write_a: assert property (
      wr_status && !SOFT_RESET
      |=> status_reg.direct_bank_sel == $past(REG_WR_DATA[6:5]))
      else $error("bank bits not written");

   clear_file_a: assert property (
      wr_status && REG_WR_DATA == 8'h00 && ALU_OP == cso_pkg::ALU_PASS
      && ALU_B == 8'h00 && FLAG_UPD == 3'b100 && !SOFT_RESET
      |=> status_reg.zero && status_reg.direct_bank_sel == 2'b00
          && !status_reg.indirect_bank_bit
          && status_reg.carry == $past(status_reg.carry))
      else $error("status clear gave wrong value");

   pull_off_a: assert property (
      option_reg.pull_resistor_disable |=> PULL_EN == 6'h00)
      else $error("pulls enabled while disabled");

   timer_direct_a: assert property (
      option_reg.prescale_owner |-> TMR_TICK == tmr_src)
      else $error("timer divided while prescaler is with watchdog");

   option_soft_a: assert property (
      SOFT_RESET |=> option_reg == cso_pkg::OPTION_RST
                     && status_reg.direct_bank_sel == 2'b00)
      else $error("soft reset values wrong");

   sub_borrow_a: assert property (
      ALU_OP == cso_pkg::ALU_SUB |-> alu_flags.carry == (ALU_A >= ALU_B))
      else $error("subtract carry is not inverted borrow");

   rotate_out_a: assert property (
      ALU_OP == cso_pkg::ALU_ROTR |-> alu_flags.carry == ALU_A[0])
      else $error("rotate right carry wrong");

   irq_edge_a: assert property (
      option_reg.pin_irq_edge && !irq_pin_reg && EXT_IRQ_PIN
      |-> EXT_IRQ_EVENT)
      else $error("rising edge missed");

   power_reset_a: assert property (
      @(posedge MCLK) $fell(RESET)
      |-> status_reg[7:3] == cso_pkg::STATUS_PWR_HI
          && option_reg == cso_pkg::OPTION_RST)
      else $error("power reset values wrong");

   option_write_a: assert property (
      wr_option && !SOFT_RESET |=> option_reg == $past(REG_WR_DATA))
      else $error("option write not taken");

   timeout_clear_a: assert property (
      WDT_TIMEOUT_EV && !SOFT_RESET |=> !status_reg.wdt_expiry_flag)
      else $error("timeout did not clear expiry flag");

   flag_block_a: assert property (
      wr_status && FLAG_UPD == 3'b100 && !SOFT_RESET
      |=> status_reg[1:0] == $past(status_reg[1:0]))
      else $error("data write reached suppressed flag bits");

   soft_status_a: assert property (
      SOFT_RESET |=> status_reg.wdt_expiry_flag == !$past(SOFT_RST_WDT)
                     && status_reg[3:0] == $past(status_reg[3:0]))
      else $error("other reset changed status wrongly");

   rotate_left_a: assert property (
      ALU_OP == cso_pkg::ALU_ROTL |-> alu_flags.carry == ALU_A[7])
      else $error("rotate left carry wrong");

   irq_fall_a: assert property (
      !option_reg.pin_irq_edge && irq_pin_reg && !EXT_IRQ_PIN
      |-> EXT_IRQ_EVENT)
      else $error("falling edge missed");

   tick_fall_a: assert property (
      option_reg.tick_edge_pick && tick_pin_reg && !EXT_TICK_PIN
      |-> tick_edge)
      else $error("falling tick edge missed");

   tick_internal_a: assert property (
      !option_reg.tick_source_sel |-> tmr_src == INSTR_CYCLE_EN)
      else $error("timer source is not the instruction clock");

   wdt_direct_a: assert property (
      !option_reg.prescale_owner |-> WDT_TICK == WDT_BASE_TICK)
      else $error("watchdog divided while prescaler is with timer");

   pull_follow_a: assert property (
      !option_reg.pull_resistor_disable |=> PULL_EN == $past(PORT_LATCH))
      else $error("pull enables do not follow the latch");

   status_write_c: cover property (wr_status ##1 FLAG_UPD != 3'b000);
   clear_file_c: cover property (wr_status && FLAG_UPD == 3'b100);
   soft_reset_c: cover property (SOFT_RESET && SOFT_RST_WDT);
   timeout_c: cover property (WDT_TIMEOUT_EV ##1 CLRWDT_EV);
   timer_div_c: cover property (!option_reg.prescale_owner && TMR_TICK);

endmodule : cso_core_regs

// ==== rtl/cso_pkg.sv ====
package cso_pkg;

   // Register locations in the core register space
   localparam logic [8:0] STATUS_ADDR   = 9'h003;
   localparam logic [6:0] STATUS_LOW    = 7'h03;
   localparam logic [8:0] OPTION_ADDR   = 9'h081;

   // Reset values
   localparam logic [7:0] OPTION_RST    = 8'hFF;
   localparam logic [4:0] STATUS_PWR_HI = 5'h03;
   localparam logic [2:0] ALU_FLAG_RST  = 3'h0;
   localparam logic [7:0] READ_ZERO     = 8'h00;

   // Positions in the flag-update mask
   localparam int FLG_Z  = 2;
   localparam int FLG_DC = 1;
   localparam int FLG_C  = 0;

   typedef enum logic [2:0] {
      ALU_PASS = 3'h0,
      ALU_ADD  = 3'h1,
      ALU_SUB  = 3'h2,
      ALU_ROTL = 3'h3,
      ALU_ROTR = 3'h4,
      ALU_SWAP = 3'h5
   } cso_op_t;

   typedef struct packed {
      logic       indirect_bank_bit;
      logic [1:0] direct_bank_sel;
      logic       wdt_expiry_flag;
      logic       sleep_entry_flag;
      logic       zero;
      logic       nibble_overflow_flag;
      logic       carry;
   } cso_status_t;

   typedef struct packed {
      logic       pull_resistor_disable;
      logic       pin_irq_edge;
      logic       tick_source_sel;
      logic       tick_edge_pick;
      logic       prescale_owner;
      logic [2:0] prescale_ratio;
   } cso_option_t;

   typedef struct packed {
      logic zero;
      logic nibble_overflow_flag;
      logic carry;
   } cso_flags_t;

endpackage : cso_pkg

// ==== rtl/cso_flag_unit.sv ====
`timescale 1ns/1ps
module cso_flag_unit (
   // Operation
   input  wire cso_pkg::cso_op_t op,
   input  wire logic [7:0]       a,
   input  wire logic [7:0]       b,
   input  wire logic             carry_in,
   // Result
   output logic [7:0]            result,
   output cso_pkg::cso_flags_t   flags
);

   always_comb
   begin
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] operand_b;
      logic       sub_in;
      sub_in    = (op == cso_pkg::ALU_SUB);
      // Subtract adds the two's complement, so carries read as not-borrow
      operand_b = sub_in ? ~b : b;
      sum       = {1'b0, a} + {1'b0, operand_b} + {8'h00, sub_in};
      nib       = {1'b0, a[3:0]} + {1'b0, operand_b[3:0]}
                  + {4'h0, sub_in};
      result                     = b;
      flags.carry                = carry_in;
      flags.nibble_overflow_flag = 1'b0;
      case (op)
         cso_pkg::ALU_ADD, cso_pkg::ALU_SUB:
         begin
            result                     = sum[7:0];
            flags.carry                = sum[8];
            flags.nibble_overflow_flag = nib[4];
         end
         cso_pkg::ALU_ROTL:
         begin
            result      = {a[6:0], carry_in};
            flags.carry = a[7];
         end
         cso_pkg::ALU_ROTR:
         begin
            result      = {carry_in, a[7:1]};
            flags.carry = a[0];
         end
         cso_pkg::ALU_SWAP:
            result = {a[3:0], a[7:4]};
         default:
            result = b;
      endcase
      flags.zero = (result == 8'h00);
   end

endmodule : cso_flag_unit

// ==== rtl/cso_prescaler.sv ====
`timescale 1ns/1ps
module cso_prescaler (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Control
   input  wire logic       owner,
   input  wire logic [2:0] ratio,
   // Source ticks
   input  wire logic       tmr_in,
   input  wire logic       wdt_in,
   // Divided ticks
   output logic            tmr_tick,
   output logic            wdt_tick
);

   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic       owner_reg;
   logic       owner_next;
   logic [7:0] mask;
   logic       in_tick;
   logic       hit;

   function automatic logic [7:0] ratio_mask(input logic [3:0] shift);
      ratio_mask = 8'((9'h001 << shift) - 9'h001);
   endfunction : ratio_mask

   // Timer sees one extra halving compared to the watchdog
   always_comb
   begin
      mask    = owner ? ratio_mask({1'b0, ratio})
                      : ratio_mask({1'b0, ratio} + 4'h1);
      in_tick = owner ? wdt_in : tmr_in;
      hit     = in_tick && ((cnt_reg & mask) == mask);
      tmr_tick = owner ? tmr_in : hit;
      wdt_tick = owner ? hit : wdt_in;
      owner_next = owner;
      // Reassignment restarts the count so no stale partial count leaks
      if (owner != owner_reg)
         cnt_next = 8'h00;
      else if (in_tick)
         cnt_next = cnt_reg + 8'h01;
      else
         cnt_next = cnt_reg;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_reg   <= 8'h00;
         owner_reg <= 1'b1;
      end
      else
      begin
         cnt_reg   <= cnt_next;
         owner_reg <= owner_next;
      end
   end

endmodule : cso_prescaler

// ==== sim/tb_core_status_and_option_regs.sv ====
`timescale 1ns/1ps
module tb_core_status_and_option_regs;
   typedef struct {
      int         due;
      int         kind;
      logic [8:0] val;
   } cso_note_t;
   localparam logic [8:0] SA = cso_pkg::STATUS_ADDR;
   localparam logic [8:0] OA = cso_pkg::OPTION_ADDR;
   logic             MCLK, RESET, SOFT_RESET, SOFT_RST_WDT;
   logic             REG_WR_EN, CLRWDT_EV, SLEEP_EV, WDT_TIMEOUT_EV;
   logic             EXT_IRQ_PIN, EXT_IRQ_EVENT, EXT_TICK_PIN;
   logic             INSTR_CYCLE_EN, WDT_BASE_TICK, TMR_TICK, WDT_TICK;
   logic [8:0]       REG_ADDR, DIRECT_ADDR, INDIRECT_ADDR;
   logic [7:0]       REG_WR_DATA, REG_RD_DATA, ALU_A, ALU_B, ALU_RESULT;
   logic [7:0]       FSR_VAL, st, opt, a;
   logic [6:0]       FILE_ADDR;
   logic [5:0]       PORT_LATCH, PULL_EN;
   logic [2:0]       FLAG_UPD;
   logic [31:0]      seed, v;
   logic             pin, tp, t;
   cso_pkg::cso_op_t ALU_OP;
   cso_note_t        notes[$];
   cso_note_t        n;
   int               fails, check_count, ncnt, k;
   cso_pkg::cso_op_t optab[10] = '{cso_pkg::ALU_ADD, cso_pkg::ALU_SUB,
      cso_pkg::ALU_ADD, cso_pkg::ALU_SUB, cso_pkg::ALU_SUB,
      cso_pkg::ALU_ROTL, cso_pkg::ALU_ROTR, cso_pkg::ALU_ROTL,
      cso_pkg::ALU_SWAP, cso_pkg::ALU_PASS};
   logic [2:0]       futab[10] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
      3'h1, 3'h1, 3'h1, 3'h0, 3'h0};
   // {soft reset, watchdog cause, clear, sleep, timeout}
   logic [4:0]       pl[6] = '{5'h01, 5'h02, 5'h04, 5'h03, 5'h18, 5'h10};

   cso_core_regs uut (.MCLK, .RESET, .SOFT_RESET, .SOFT_RST_WDT,
      .REG_WR_EN, .REG_ADDR, .REG_WR_DATA, .REG_RD_DATA, .ALU_OP, .ALU_A,
      .ALU_B, .FLAG_UPD, .ALU_RESULT, .FILE_ADDR, .FSR_VAL, .DIRECT_ADDR,
      .INDIRECT_ADDR, .CLRWDT_EV, .SLEEP_EV, .WDT_TIMEOUT_EV, .PORT_LATCH,
      .PULL_EN, .EXT_IRQ_PIN, .EXT_IRQ_EVENT, .EXT_TICK_PIN,
      .INSTR_CYCLE_EN, .WDT_BASE_TICK, .TMR_TICK, .WDT_TICK);

   initial
   begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [8:0] seen(input int kd);
      case (kd)
         0: return {1'b0, REG_RD_DATA};
         1: return {1'b0, ALU_RESULT};
         2: return DIRECT_ADDR;
         3: return INDIRECT_ADDR;
         4: return {3'h0, PULL_EN};
         5: return {8'h00, EXT_IRQ_EVENT};
         6: return {8'h00, TMR_TICK};
         default: return {8'h00, WDT_TICK};
      endcase
   endfunction : seen

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // Outputs are settled by the falling edge; notes fall due in order
   always @(negedge MCLK)
   begin
      ncnt = ncnt + 1;
      while (notes.size() > 0 && notes[0].due <= ncnt)
      begin
         n = notes.pop_front();
         check(seen(n.kind), n.val);
      end
   end

   initial
   begin
      repeat (20000) @(posedge MCLK);
      fails++;
      tally_and_finish();
   end

   task automatic note(input int d, input int kd, input logic [8:0] val);
      notes.push_back('{ncnt + 1 + d, kd, val});
   endtask : note

   task automatic bus(input logic we, input logic [8:0] ad,
                      input logic [7:0] d, input logic [2:0] fu);
      @(posedge MCLK);
      REG_WR_EN   <= we;
      REG_ADDR    <= ad;
      REG_WR_DATA <= d;
      FLAG_UPD    <= fu;
   endtask : bus

   task automatic rd(input logic [8:0] ad, input logic [7:0] e);
      bus(1'b0, ad, 8'h00, 3'h0);
      note(1, 0, {1'b0, e});
   endtask : rd

   task automatic wr(input logic [8:0] ad, input logic [7:0] d);
      bus(1'b1, ad, d, 3'h0);
      if (ad[6:0] == cso_pkg::STATUS_LOW)
         st = {d[7:5], st[4:3], d[2:0]};
      if (ad == OA)
         opt = d;
   endtask : wr

   task automatic alu(input cso_pkg::cso_op_t op, input logic [7:0] x,
      input logic [7:0] y, input logic [2:0] fu, input logic we,
      input logic [7:0] d);
      logic [7:0] r;
      logic [2:0] f;
      f = 3'h0;
      case (op)
         cso_pkg::ALU_ADD:  {f[0], r} = {1'b0, x} + {1'b0, y};
         cso_pkg::ALU_SUB:  {f[0], r} = {x >= y, x - y};
         cso_pkg::ALU_ROTL: {f[0], r} = {x, st[0]};
         cso_pkg::ALU_ROTR: {r, f[0]} = {st[0], x};
         cso_pkg::ALU_SWAP: r = {x[3:0], x[7:4]};
         default:           r = y;
      endcase
      if (op == cso_pkg::ALU_SUB)
         f[1] = x[3:0] >= y[3:0];
      else
         f[1] = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F;
      f[2] = (r == 8'h00);
      bus(we, SA, d, fu);
      ALU_OP <= op;
      ALU_A  <= x;
      ALU_B  <= y;
      note(0, 1, {1'b0, r});
      if (we)
         st = {d[7:5], st[4:3], (fu != 3'h0) ? st[2:0] : d[2:0]};
      for (int i = 0; i < 3; i++)
         if (fu[i])
            st[i] = f[i];
      rd(SA, st);
   endtask : alu

   task automatic pulse(input logic [4:0] p);
      bus(1'b0, SA, 8'h00, 3'h0);
      {SOFT_RESET, SOFT_RST_WDT, CLRWDT_EV, SLEEP_EV, WDT_TIMEOUT_EV} <= p;
      if (p[4])
      begin
         st = {3'h0, ~p[3], st[3:0]};
         opt = 8'hFF;
      end
      else
      begin
         if (p[1])
            st[3] = 1'b0;
         else if (p[2])
            st[3] = 1'b1;
         if (p[0])
            st[4] = 1'b0;
         else if (p[2] | p[1])
            st[4] = 1'b1;
      end
      bus(1'b0, SA, 8'h00, 3'h0);
      {SOFT_RESET, SOFT_RST_WDT, CLRWDT_EV, SLEEP_EV, WDT_TIMEOUT_EV} <= '0;
      note(1, 0, {1'b0, st});
      rd(OA, opt);
   endtask : pulse

   initial
   begin
      {SOFT_RESET, SOFT_RST_WDT, REG_WR_EN, CLRWDT_EV, SLEEP_EV,
       WDT_TIMEOUT_EV, EXT_IRQ_PIN, EXT_TICK_PIN, INSTR_CYCLE_EN,
       WDT_BASE_TICK} = '0;
      {REG_ADDR, REG_WR_DATA, ALU_A, ALU_B, FSR_VAL, FILE_ADDR,
       PORT_LATCH, FLAG_UPD} = '0;
      ALU_OP = cso_pkg::ALU_PASS;
      RESET = 1'b1;
      seed = 32'hF7FA;
      {st, opt, pin, tp} = {8'h18, 8'hFF, 2'b00};
      repeat (5) @(posedge MCLK);
      RESET <= 1'b0;
      rd(SA, 8'h18);
      note(1, 4, 9'h000);
      rd(OA, 8'hFF);
      repeat (4)
      begin
         wr(OA, 8'(rnd()));
         rd(OA, opt);
      end
      wr(9'h101, ~opt);
      rd(OA, opt);
      rd(9'h101, 8'h00);
      wr(9'h005, 8'h5A);
      rd(9'h005, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         wr({i[1:0], cso_pkg::STATUS_LOW}, {i[2:0], 5'(rnd())});
         bus(1'b0, SA, 8'h00, 3'h0);
         v = rnd();
         FILE_ADDR <= v[6:0];
         FSR_VAL   <= v[15:8];
         note(0, 2, {st[6:5], v[6:0]});
         note(0, 3, {st[7], v[15:8]});
         note(1, 0, {1'b0, st});
      end
      alu(cso_pkg::ALU_ADD, 8'hFF, 8'h01, 3'h7, 1'b1, 8'hE0);
      alu(cso_pkg::ALU_PASS, 8'h00, 8'h00, 3'h4, 1'b1, 8'h00);
      for (int i = 0; i < 10; i++)
      begin
         a = 8'(rnd());
         alu(optab[i], a, (i >= 4 && i < 9) ? a : 8'(rnd()), futab[i],
             1'b0, 8'h00);
      end
      foreach (pl[j])
         pulse(pl[j]);
      for (int j = 0; j < 2; j++)
      begin
         wr(OA, (j != 0) ? 8'hFF : 8'h7F);
         repeat (6)
         begin
            bus(1'b0, SA, 8'h00, 3'h0);
            v = rnd();
            PORT_LATCH <= v[5:0];
            note(1, 4, opt[7] ? 9'h000 : {3'h0, v[5:0]});
         end
      end
      for (int j = 0; j < 2; j++)
      begin
         wr(OA, (j != 0) ? 8'hFF : 8'hBF);
         repeat (10)
         begin
            bus(1'b0, SA, 8'h00, 3'h0);
            v = rnd();
            EXT_IRQ_PIN <= v[0];
            t = (j != 0) ? (v[0] & ~pin) : (~v[0] & pin);
            note(0, 5, {8'h00, t});
            pin = v[0];
         end
      end
      // Owner toggles twice so the shared count restarts from zero
      for (int o = 0; o < 2; o++)
         for (int r = 0; r < 8; r++)
         begin
            wr(OA, {4'hC, ~o[0], 3'h0});
            wr(OA, {4'hC, o[0], r[2:0]});
            bus(1'b0, SA, 8'h00, 3'h0);
            bus(1'b0, SA, 8'h00, 3'h0);
            k = 0;
            for (int i = 0; i < ((4 << r) >> o); i++)
            begin
               bus(1'b0, SA, 8'h00, 3'h0);
               v = rnd();
               t = v[0] | v[1];
               INSTR_CYCLE_EN <= t;
               WDT_BASE_TICK  <= t;
               k = k + int'(t);
               note(0, 6, {8'h00, t & (o[0] | (k % (2 << r) == 0))});
               note(0, 7, {8'h00, t & (!o[0] | (k % (1 << r) == 0))});
            end
            bus(1'b0, SA, 8'h00, 3'h0);
            INSTR_CYCLE_EN <= 1'b0;
            WDT_BASE_TICK  <= 1'b0;
         end
      for (int j = 0; j < 2; j++)
      begin
         wr(OA, {3'h7, j[0], 4'hC});
         repeat (12)
         begin
            bus(1'b0, SA, 8'h00, 3'h0);
            v = rnd();
            EXT_TICK_PIN   <= v[0];
            INSTR_CYCLE_EN <= v[1];
            t = (j != 0) ? (~v[0] & tp) : (v[0] & ~tp);
            note(0, 6, {8'h00, t});
            tp = v[0];
         end
      end
      bus(1'b0, SA, 8'h00, 3'h0);
      INSTR_CYCLE_EN <= 1'b0;
      repeat (4) bus(1'b0, SA, 8'h00, 3'h0);
      tally_and_finish();
   end
endmodule : tb_core_status_and_option_regs
